//--- src/nco_pll_config_regs.sv
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
module nco_pll_config_regs
  import nco_pll_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [9:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [2:0]  i_lf_level,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  output logic [31:0]      o_freq_word_first_path,
  output logic [31:0]      o_freq_word_second_path,
  output logic [31:0]      o_acc_first_path,
  output logic [31:0]      o_acc_second_path,
  output mult_cfg_t        o_mult_cfg
);
  state_t q;
  state_t d;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] sel);
    merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  logic       req;
  logic [7:0] idx;
  logic       aligned;
  assign req     = i_wb_cyc && i_wb_stb && !q.ack;
  assign idx     = i_wb_adr[9:2];
  assign aligned = i_wb_adr[1:0] == 2'b00;

  always_comb begin
    d       = q;
    d.ack   = req;
    d.dat   = UNMAPPED_DATA;
    // Three-stage sync; level counts only once stages two and three agree
    d.lf_s1 = i_lf_level;
    d.lf_s2 = q.lf_s1;
    d.lf_s3 = q.lf_s2;
    if (q.lf_s2 == q.lf_s3) begin
      d.lf_level = q.lf_s3;
    end
    if (req && aligned) begin
      unique case (idx)
        IDX_FREQ_ABL: d.dat = {16'h0000, q.freq_abl};
        IDX_FREQ_ABH: d.dat = {16'h0000, q.freq_abh};
        IDX_FREQ_CDL: d.dat = {16'h0000, q.freq_cdl};
        IDX_FREQ_CDH: d.dat = {16'h0000, q.freq_cdh};
        IDX_PHASE_AB: d.dat = {16'h0000, q.phase_ab};
        IDX_PHASE_CD: d.dat = {16'h0000, q.phase_cd};
        IDX_MULT_CTL: d.dat = {16'h0000, q.mult_ctl[15:3], q.lf_level};
        IDX_MULT_DIV: d.dat = {16'h0000, q.mult_div};
        default:      d.dat = UNMAPPED_DATA;
      endcase
      if (i_wb_we) begin
        unique case (idx)
          IDX_FREQ_ABL: d.freq_abl = merge(q.freq_abl, i_wb_dat, i_wb_sel);
          IDX_FREQ_ABH: d.freq_abh = merge(q.freq_abh, i_wb_dat, i_wb_sel);
          IDX_FREQ_CDL: d.freq_cdl = merge(q.freq_cdl, i_wb_dat, i_wb_sel);
          IDX_FREQ_CDH: d.freq_cdh = merge(q.freq_cdh, i_wb_dat, i_wb_sel);
          IDX_PHASE_AB: begin
            d.phase_ab = merge(q.phase_ab, i_wb_dat, i_wb_sel);
            d.act_ab   = {q.freq_abh, q.freq_abl};
          end
          IDX_PHASE_CD: begin
            d.phase_cd = merge(q.phase_cd, i_wb_dat, i_wb_sel);
            d.act_cd   = {q.freq_cdh, q.freq_cdl};
          end
          // Reserved and read-only bits keep their values whatever is written
          IDX_MULT_CTL: d.mult_ctl = (merge(q.mult_ctl, i_wb_dat, i_wb_sel) & ~(CTL_RSVD_MASK | CTL_RO_MASK))
                                   | (RST_MULT_CTL & (CTL_RSVD_MASK | CTL_RO_MASK));
          IDX_MULT_DIV: d.mult_div = (merge(q.mult_div, i_wb_dat, i_wb_sel) & ~DIV_RSVD_MASK)
                                   | (RST_MULT_DIV & DIV_RSVD_MASK);
          default: ;
        endcase
      end
    end
    // Signed word added as unsigned gives the same modulo result
    d.acc_ab = q.acc_ab + q.act_ab;
    d.acc_cd = q.acc_cd + q.act_cd;
    d.cfg.clamp     = q.mult_ctl[BIT_CLAMP];
    d.cfg.nsync_ena = q.mult_ctl[BIT_NSYNC];
    d.cfg.mult_ena  = q.mult_ctl[BIT_ENA];
    d.cfg.pump      = pump_t'(q.mult_ctl[POS_PUMP +: 2]);
    d.cfg.presc_ratio = (q.mult_ctl[POS_PRESC +: 3] == 3'b000) ? 4'h8
                      : {1'b0, q.mult_ctl[POS_PRESC +: 3]};
    if (q.mult_div[POS_MDIV + 7]) begin
      d.cfg.m_div   = {1'b0, q.mult_div[POS_MDIV +: 7], 1'b0};
      d.cfg.m_valid = q.mult_div[POS_MDIV +: 7] >= 7'h04;
    end else begin
      d.cfg.m_div   = {2'b00, q.mult_div[POS_MDIV +: 7]};
      d.cfg.m_valid = q.mult_div[POS_MDIV +: 7] >= 7'h04;
    end
    d.cfg.n_div     = {1'b0, q.mult_div[POS_NDIV +: 4]} + 5'h01;
    d.cfg.bias_tune = q.mult_div[POS_BIAS +: 2];
    if (i_srst) begin
      d          = '0;
      d.freq_abl = RST_FREQ;
      d.freq_abh = RST_FREQ;
      d.freq_cdl = RST_FREQ;
      d.freq_cdh = RST_FREQ;
      d.phase_ab = RST_PHASE;
      d.phase_cd = RST_PHASE;
      d.mult_ctl = RST_MULT_CTL;
      d.mult_div = RST_MULT_DIV;
    end
  end

  always_ff @(posedge i_clock) begin
    q <= d;
  end

  assign o_wb_dat                = q.dat;
  assign o_wb_ack                = q.ack;
  assign o_freq_word_first_path  = q.act_ab;
  assign o_freq_word_second_path = q.act_cd;
  assign o_acc_first_path        = q.acc_ab;
  assign o_acc_second_path       = q.acc_cd;
  assign o_mult_cfg              = q.cfg;
endmodule // nco_pll_config_regs

//--- src/nco_pll_pkg.sv
// Overview of operation
// - First path frequency word is 32 bits: low half at 0x14, high at 0x15.
// - Second path frequency word is 32 bits: low half at 0x16, high at 0x17.
// - Frequency words are two's complement; one step is Fs over two to 32.
// - Clamp bit 12 set holds the multiplier loop filter at zero volts.
// - Bit 11 set lets the sync input align the N dividers; resets to one.
// - Bit 10 set enables the multiplier; clear bypasses it to input clock.
// - Pump field 7:6 decodes none, single, unused, dual.
// - Prescaler field 5:3: codes 2 to 7 give ratio 2 to 7, 0 gives 8.
// - Read-only loop-filter level at bits 2:0, steps of 0.4125 volts.
// - M bit 7 clear: divider equals low seven bits, valid 4 to 127.
// - M bit 7 set: divider equals twice low seven bits, 8 to 254.
// - N field 7:4 gives divider equal to code plus one, 1 to 16.
// - Frequency words take effect only when the phase offset register is written.
package nco_pll_pkg;
  localparam logic [7:0]  IDX_PHASE_AB  = 8'h12;
  localparam logic [7:0]  IDX_PHASE_CD  = 8'h13;
  localparam logic [7:0]  IDX_FREQ_ABL  = 8'h14;
  localparam logic [7:0]  IDX_FREQ_ABH  = 8'h15;
  localparam logic [7:0]  IDX_FREQ_CDL  = 8'h16;
  localparam logic [7:0]  IDX_FREQ_CDH  = 8'h17;
  localparam logic [7:0]  IDX_MULT_CTL  = 8'h18;
  localparam logic [7:0]  IDX_MULT_DIV  = 8'h19;
  localparam logic [15:0] RST_FREQ      = 16'h0000;
  localparam logic [15:0] RST_PHASE     = 16'h0000;
  localparam logic [15:0] RST_MULT_CTL  = 16'h2808;
  localparam logic [15:0] RST_MULT_DIV  = 16'h0440;
  localparam logic [15:0] CTL_RSVD_MASK = 16'hE300;
  localparam logic [15:0] DIV_RSVD_MASK = 16'h0003;
  localparam logic [15:0] CTL_RO_MASK   = 16'h0007;
  localparam int          BIT_CLAMP     = 12;
  localparam int          BIT_NSYNC     = 11;
  localparam int          BIT_ENA       = 10;
  localparam int          POS_PUMP      = 6;
  localparam int          POS_PRESC     = 3;
  localparam int          POS_MDIV      = 8;
  localparam int          POS_NDIV      = 4;
  localparam int          POS_BIAS      = 2;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [1:0] {PUMP_NONE, PUMP_SINGLE, PUMP_UNUSED, PUMP_DUAL} pump_t;

  typedef struct packed {
    logic       clamp;
    logic       nsync_ena;
    logic       mult_ena;
    pump_t      pump;
    logic [3:0] presc_ratio;
    logic [8:0] m_div;
    logic       m_valid;
    logic [4:0] n_div;
    logic [1:0] bias_tune;
  } mult_cfg_t;

  typedef struct packed {
    logic [15:0] freq_abl;
    logic [15:0] freq_abh;
    logic [15:0] freq_cdl;
    logic [15:0] freq_cdh;
    logic [15:0] phase_ab;
    logic [15:0] phase_cd;
    logic [15:0] mult_ctl;
    logic [15:0] mult_div;
    logic [31:0] act_ab;
    logic [31:0] act_cd;
    logic [31:0] acc_ab;
    logic [31:0] acc_cd;
    logic [31:0] dat;
    logic        ack;
    mult_cfg_t   cfg;
    logic [2:0]  lf_s1;
    logic [2:0]  lf_s2;
    logic [2:0]  lf_s3;
    logic [2:0]  lf_level;
  } state_t;
endpackage

//--- testbench/nco_pll_config_regs_chk.sv
`timescale 1ns/1ps
module nco_pll_config_regs_chk
  import nco_pll_pkg::*; (
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire mult_cfg_t   o_mult_cfg);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  a_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack unasked");
  a_read_upper: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0000) else $error("upper");
  a_presc_range: assert property (!$past(i_srst) |-> o_mult_cfg.presc_ratio inside {[1:8]}) else $error("presc");
  a_n_range: assert property (!$past(i_srst) |-> o_mult_cfg.n_div inside {[1:16]}) else $error("n");
  a_m_valid: assert property (o_mult_cfg.m_valid |-> o_mult_cfg.m_div inside {[4:254]}) else $error("m");
  a_m_invalid: assert property (!o_mult_cfg.m_valid |-> o_mult_cfg.m_div < 9'h008) else $error("m bad");
endmodule // nco_pll_config_regs_chk
bind nco_pll_config_regs nco_pll_config_regs_chk u_nco_pll_config_regs_chk (.i_clock(i_clock), .i_srst(i_srst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_mult_cfg(o_mult_cfg));

//--- testbench/nco_pll_config_regs_test.sv
`timescale 1ns/1ps
module nco_pll_config_regs_test;
  import nco_pll_pkg::*;
  logic        i_clock = 1'h0, i_srst = 1'h1, cyc = 1'h0, we = 1'h0, ack;
  logic [9:0]  adr = 10'h000;
  logic [15:0] wd = 16'h0000;
  logic [2:0]  lvl = 3'h0;
  logic [31:0] rdat, fa, fb, acc, a0;
  mult_cfg_t   cfg;
  int          num_errors = 0, comparisons = 0;
  nco_pll_config_regs u_nco_pll_config_regs (.i_clock(i_clock), .i_srst(i_srst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h3), .i_wb_dat({16'h0000, wd}), .i_lf_level(lvl), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_freq_word_first_path(fa), .o_freq_word_second_path(fb), .o_acc_first_path(acc),
    .o_acc_second_path(), .o_mult_cfg(cfg));
  initial forever #12.5 i_clock = ~i_clock;
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    num_errors += int'(g !== e);
    if (g !== e) $display("BAD %s expected %h seen %h", n, e, g);
  endtask
  task automatic wb(input logic w, input logic [7:0] i, input logic [15:0] d, input logic [31:0] e);
    {cyc, we, adr, wd} <= {1'h1, w, i, 2'h0, d};
    do @(posedge i_clock); while (ack !== 1'h1);
    if (!w) chk("read", rdat, e);
    cyc <= 1'h0;
    @(posedge i_clock);
  endtask
  task automatic t_reset;
    for (int k = 0; k < 4; k++) wb(1'h0, IDX_FREQ_ABL + 8'(k), 16'h0, 32'h0);
    wb(1'h0, IDX_MULT_CTL, 16'h0, 32'h2808);
    wb(1'h0, IDX_MULT_DIV, 16'h0, 32'h0440);
  endtask
  task automatic t_words;
    wb(1'h1, IDX_FREQ_ABL, 16'h5678, 32'h0);
    wb(1'h1, IDX_FREQ_ABH, 16'hF234, 32'h0);
    wb(1'h1, IDX_FREQ_CDH, 16'h8001, 32'h0);
    chk("idle", fa | fb, 32'h0);
    wb(1'h1, IDX_PHASE_AB, 16'h0, 32'h0);
    chk("ab", fa, 32'hF2345678);
    a0 = acc;
    @(posedge i_clock);
    chk("acc", acc - a0, 32'hF2345678);
    wb(1'h1, IDX_PHASE_CD, 16'h0, 32'h0);
    chk("cd", fb, 32'h80010000);
  endtask
  task automatic t_regs;
    logic [2:0] c, p;
    lvl <= 3'h5;
    for (int k = 0; k < 8; k++) begin
      c = 3'(k);
      p = c ^ {2'h0, c == 3'h1};
      wb(1'h1, IDX_MULT_CTL, {3'h7, c, 2'h3, c[1:0], p, 3'h2}, 32'h0);
      wb(1'h1, IDX_MULT_DIV, {c[0], 4'h0, c, c, c[0], 4'h7}, 32'h0);
      chk("ctl", {cfg.clamp, cfg.nsync_ena, cfg.mult_ena, cfg.pump, cfg.presc_ratio}, {c, c[1:0], p == 3'h0, p});
      chk("div", {cfg.m_div, cfg.m_valid, cfg.n_div, cfg.bias_tune},
        {c[0] ? {5'h00, c, 1'h0} : {6'h00, c}, c[2], 5'({c, c[0]}) + 5'h01, 2'h1});
      wb(1'h0, IDX_MULT_CTL, 16'h0, {16'h0, 3'h1, c, 2'h0, c[1:0], p, 3'h5});
      wb(1'h0, IDX_MULT_DIV, 16'h0, {16'h0, c[0], 4'h0, c, c, c[0], 4'h4});
    end
    wb(1'h0, 8'h1A, 16'h0, 32'h0);
  endtask
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clock);
    i_srst <= 1'h0;
    @(posedge i_clock);
    t_reset;
    t_words;
    t_regs;
    test_done;
  end
  initial begin
    repeat (3000) @(posedge i_clock);
    num_errors++;
    test_done;
  end
endmodule // nco_pll_config_regs_test
